// ### logic/buck_ctrl_pkg.sv
package buck_ctrl_pkg;

    // Channel count and field widths
    localparam int NUM_CH = 4;
    localparam int CODE_W = 8;
    localparam int ADDR_W = 8;
    localparam int TICK_W = 7;

    // Voltage codes: linear 0..176, then one high setting
    localparam logic [7:0] VCODE_LIN_MAX = 8'hB0;
    localparam logic [7:0] VCODE_HIGH = 8'hB1;

    // Operating modes
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_PWM = 2'h1;
    localparam logic [1:0] MODE_PFM = 2'h2;
    localparam logic [1:0] MODE_AUTO = 2'h3;

    // Oscillator ticks per 6.25 mV step, up and down, per ramp code
    localparam logic [6:0] UP_TICKS_00 = 7'h10;
    localparam logic [6:0] UP_TICKS_01 = 7'h08;
    localparam logic [6:0] UP_TICKS_10 = 7'h20;
    localparam logic [6:0] UP_TICKS_11 = 7'h40;
    localparam logic [6:0] DN_TICKS_00 = 7'h18;
    localparam logic [6:0] DN_TICKS_01 = 7'h0C;
    localparam logic [6:0] DN_TICKS_10 = 7'h30;
    localparam logic [6:0] DN_TICKS_11 = 7'h60;
    // Oscillator ticks a channel stays off around a jump to or from 1.8 V
    localparam logic [6:0] BLANK_TICKS = 7'h08;

    // System clock in MHz and oscillator code decoding
    localparam logic [6:0] SYS_MHZ = 7'h7D;
    localparam logic [6:0] OSC_BASE_HI = 7'h14;
    localparam logic [3:0] OSC_HI_LAST = 4'h4;
    localparam logic [3:0] OSC_LO_FIRST = 4'h9;
    localparam logic [3:0] OSC_LO_LAST = 4'hC;
    localparam logic [6:0] OSC_LO_OFFSET = 7'h07;
    localparam logic [2:0] PHASE_ZERO = 3'h7;

    // Register map: per channel block, then globals
    localparam logic [7:0] CH_STRIDE = 8'h08;
    localparam logic [2:0] REG_RUN_V = 3'h0;
    localparam logic [2:0] REG_STBY_V = 3'h1;
    localparam logic [2:0] REG_MODE = 3'h2;
    localparam logic [2:0] REG_CFG = 3'h3;
    localparam logic [2:0] REG_EFF_V = 3'h4;
    localparam logic [2:0] REG_STAT = 3'h5;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h20;
    localparam logic [7:0] REG_IRQ_MASK = 8'h21;
    localparam logic [7:0] REG_OSC_FREQ = 8'h22;

    // Reset values of fields with no fuse
    localparam logic [1:0] ILIM_RESET = 2'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;

    // Fuse defaults of one channel
    typedef struct packed {
        logic [7:0] voltageDefault;
        logic [1:0] rampDefault;
        logic [2:0] phaseDefault;
        logic [1:0] inductorSelect;
        logic inSequence;
    } fuse_cfg_t;

    // Controls driven to one power stage
    typedef struct packed {
        logic [7:0] voltageCode;
        logic [1:0] mode;
        logic enable;
        logic [1:0] currentLimit;
        logic [2:0] phase;
        logic [1:0] inductorSelect;
        logic switchPulse;
        logic ramping;
    } chan_out_t;

    // Register access port
    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

// ### logic/setpoint_ramp.sv
`timescale 1ns/1ps
`default_nettype none
module setpoint_ramp import buck_ctrl_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Setpoints
    input wire logic [7:0] initCode,
    input wire logic [7:0] targetCode,
    input wire logic [1:0] rampSel,
    input wire logic oscTick,
    // Applied state
    output logic [7:0] effCode,
    output logic blanked,
    output logic ramping
);

    typedef enum logic [1:0] {IDLE, RAMP, BLANK} ramp_st_t;

    typedef struct packed {
        ramp_st_t st;
        logic [7:0] code;
        logic [6:0] cnt;
    } ramp_state_t;

    ramp_state_t s_q, s_d;

    // Step spacing in oscillator ticks for a direction and rate
    function automatic logic [6:0] stepTicks(input logic [1:0] sel,
                                             input logic up);
        case (sel)
            2'h0: stepTicks = up ? UP_TICKS_00 : DN_TICKS_00;
            2'h1: stepTicks = up ? UP_TICKS_01 : DN_TICKS_01;
            2'h2: stepTicks = up ? UP_TICKS_10 : DN_TICKS_10;
            default: stepTicks = up ? UP_TICKS_11 : DN_TICKS_11;
        endcase
    endfunction

    logic crossHigh;
    logic goUp;
    assign crossHigh = (targetCode == VCODE_HIGH) != (s_q.code == VCODE_HIGH);
    assign goUp = targetCode > s_q.code;

    // Next state of the ramp engine
    always_comb begin
        s_d = s_q;
        case (s_q.st)
            IDLE: begin
                s_d.cnt = '0;
                if (crossHigh) begin
                    s_d.st = BLANK;
                end else if (targetCode != s_q.code) begin
                    s_d.st = RAMP;
                end
            end
            RAMP: begin
                if (crossHigh) begin
                    s_d.st = BLANK;
                    s_d.cnt = '0;
                end else if (targetCode == s_q.code) begin
                    s_d.st = IDLE;
                end else if (oscTick) begin
                    // One code at a time, spaced by the rate
                    if (s_q.cnt + 7'h01 >= stepTicks(rampSel, goUp)) begin
                        s_d.cnt = '0;
                        s_d.code = goUp ? s_q.code + 8'h01
                                        : s_q.code - 8'h01;
                    end else begin
                        s_d.cnt = s_q.cnt + 7'h01;
                    end
                end
            end
            BLANK: begin
                if (oscTick) begin
                    s_d.cnt = s_q.cnt + 7'h01;
                end
                // Come back directly at the new level, no ramp
                if (s_q.cnt >= BLANK_TICKS) begin
                    s_d.code = targetCode;
                    s_d.st = IDLE;
                    s_d.cnt = '0;
                end
            end
            default: s_d.st = IDLE;
        endcase
    end

    // State register; reset takes the fuse code
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q.st <= IDLE;
            s_q.code <= initCode;
            s_q.cnt <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign effCode = s_q.code;
    assign blanked = s_q.st == BLANK;
    assign ramping = s_q.st == RAMP;

endmodule
`default_nettype wire

// ### logic/buck_setpoint_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Four channels, 0.4 to 1.8 V, 6.25 mV
// - Codes 0-176 linear, 177 is 1.8 V
// - Run code in run, standby code in standby
// - Both voltage codes load from fuse default
// - Fuse ramp select sets default rate
// - Software rewrites ramp select; new rate applies
// - Ramp rates scale with oscillator clock
// - Frequency code picks clock; switching is eighth
// - Gradual scaling between 0.4 and 1.5 V
// - Jumps to/from 1.8 V disable then re-enable
// - Separate run and standby two-bit modes
// - Modes load autoskip if sequenced, else off
// - Mode change raises maskable active-low interrupt
// - Current limit select 2.1/2.6/3.0/4.5 A
// - Phase code shifts switching clock in 45 degree steps
// - Phase loads from fuse; software may rewrite
// - Fuse inductor select per channel
module buck_setpoint_ctrl import buck_ctrl_pkg::*; #(
    parameter int CHANNELS = NUM_CH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Fuse defaults and device state
    input wire fuse_cfg_t [CHANNELS-1:0] fuseCfg,
    input wire logic [3:0] oscillatorFreqCode,
    input wire logic standbyState,
    // Register access from the serial interface
    input wire reg_req_t regReq,
    output logic [7:0] regRdata,
    // Power stage controls
    output chan_out_t [CHANNELS-1:0] chanOut,
    // Interrupt pin
    output logic irqOutN
);

    // The map has room for at most four channel blocks below globals
    if (CHANNELS < 1 || CHANNELS > NUM_CH) begin : gCheck
        $error("CHANNELS must be 1 to 4");
    end

    typedef struct packed {
        logic [CHANNELS-1:0][7:0] runV;
        logic [CHANNELS-1:0][7:0] stbyV;
        logic [CHANNELS-1:0][1:0] runMode;
        logic [CHANNELS-1:0][1:0] stbyMode;
        logic [CHANNELS-1:0][1:0] ramp;
        logic [CHANNELS-1:0][1:0] ilim;
        logic [CHANNELS-1:0][2:0] phase;
        logic [CHANNELS-1:0][1:0] appliedMode;
        logic [CHANNELS-1:0] irqStatus;
        logic [CHANNELS-1:0] irqMask;
        logic [7:0] rdata;
        logic [6:0] oscAcc;
        logic [2:0] oscSlot;
        logic oscTick;
    } ctrl_state_t;

    ctrl_state_t s_q, s_d;

    // Decoding of a register address
    function automatic logic isChanReg(input logic [7:0] a);
        isChanReg = a < (CH_STRIDE * 8'(CHANNELS));
    endfunction

    function automatic int unsigned chanOf(input logic [7:0] a);
        chanOf = int'(a / CH_STRIDE);
    endfunction

    function automatic logic [2:0] fieldOf(input logic [7:0] a);
        fieldOf = a[2:0];
    endfunction

    // Oscillator frequency in MHz; unlisted codes fall back to 20 MHz
    function automatic logic [6:0] oscMhz(input logic [3:0] c);
        if (c <= OSC_HI_LAST) begin
            oscMhz = OSC_BASE_HI + 7'(c);
        end else if (c >= OSC_LO_FIRST && c <= OSC_LO_LAST) begin
            oscMhz = OSC_LO_OFFSET + 7'(c);
        end else begin
            oscMhz = OSC_BASE_HI;
        end
    endfunction

    // Fuse mode default for a channel
    function automatic logic [1:0] modeDefault(input logic inSeq);
        modeDefault = inSeq ? MODE_AUTO : MODE_OFF;
    endfunction

    logic [CHANNELS-1:0][7:0] targetCode;
    logic [CHANNELS-1:0][7:0] effCode;
    logic [CHANNELS-1:0] blanked;
    logic [CHANNELS-1:0] ramping;
    logic [CHANNELS-1:0][1:0] modeNow;
    logic [CHANNELS-1:0] modeChanged;

    // Run or standby selection of code and mode
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            targetCode[i] = standbyState ? s_q.stbyV[i]
                                         : s_q.runV[i];
            modeNow[i] = standbyState ? s_q.stbyMode[i]
                                      : s_q.runMode[i];
            modeChanged[i] = modeNow[i] != s_q.appliedMode[i];
        end
    end

    // One ramp engine per channel
    for (genvar g = 0; g < CHANNELS; g++) begin : gChan
        setpoint_ramp uRamp (
            .clk(clk),
            .reset(reset),
            .initCode(fuseCfg[g].voltageDefault),
            .targetCode(targetCode[g]),
            .rampSel(s_q.ramp[g]),
            .oscTick(s_q.oscTick),
            .effCode(effCode[g]),
            .blanked(blanked[g]),
            .ramping(ramping[g])
        );
    end

    // Next state: oscillator model, register writes, interrupts, readback
    always_comb begin
        logic [7:0] a;
        logic [7:0] w;
        int unsigned ch;
        logic [7:0] sum;
        a = regReq.addr;
        w = regReq.wdata;
        ch = chanOf(a);
        s_d = s_q;

        // Fractional divider makes the oscillator rate from 125 MHz
        sum = {1'b0, s_q.oscAcc} + {1'b0, oscMhz(oscillatorFreqCode)};
        s_d.oscTick = 1'b0;
        if (sum >= {1'b0, SYS_MHZ}) begin
            s_d.oscAcc = 7'(sum - {1'b0, SYS_MHZ});
            s_d.oscTick = 1'b1;
            // Eight slots make one switching period
            s_d.oscSlot = s_q.oscSlot + 3'h1;
        end else begin
            s_d.oscAcc = sum[6:0];
        end

        // Applied mode follows the selected field
        s_d.appliedMode = modeNow;

        // Register writes
        if (regReq.write) begin
            if (isChanReg(a)) begin
                case (fieldOf(a))
                    REG_RUN_V: begin
                        // Reserved codes leave the setpoint alone
                        if (w <= VCODE_HIGH) begin
                            s_d.runV[ch] = w;
                        end
                    end
                    REG_STBY_V: begin
                        if (w <= VCODE_HIGH) begin
                            s_d.stbyV[ch] = w;
                        end
                    end
                    REG_MODE: begin
                        s_d.runMode[ch] = w[1:0];
                        s_d.stbyMode[ch] = w[3:2];
                    end
                    REG_CFG: begin
                        s_d.ramp[ch] = w[1:0];
                        s_d.ilim[ch] = w[3:2];
                        s_d.phase[ch] = w[6:4];
                    end
                    default: ;
                endcase
            end else if (a == REG_IRQ_STATUS) begin
                // Write one to clear
                s_d.irqStatus = s_q.irqStatus & ~w[CHANNELS-1:0];
            end else if (a == REG_IRQ_MASK) begin
                s_d.irqMask = w[CHANNELS-1:0];
            end
        end

        // A new mode change beats a clear in the same cycle
        s_d.irqStatus = s_d.irqStatus | modeChanged;

        // Registered readback; unmapped reads give zero
        if (regReq.read) begin
            s_d.rdata = 8'h00;
            if (isChanReg(a)) begin
                case (fieldOf(a))
                    REG_RUN_V: s_d.rdata = s_q.runV[ch];
                    REG_STBY_V: s_d.rdata = s_q.stbyV[ch];
                    REG_MODE: begin
                        s_d.rdata = {4'h0, s_q.stbyMode[ch], s_q.runMode[ch]};
                    end
                    REG_CFG: begin
                        s_d.rdata = {1'b0, s_q.phase[ch], s_q.ilim[ch],
                                     s_q.ramp[ch]};
                    end
                    REG_EFF_V: s_d.rdata = effCode[ch];
                    REG_STAT: begin
                        s_d.rdata = {4'h0, ramping[ch], blanked[ch],
                                     fuseCfg[ch].inductorSelect};
                    end
                    default: s_d.rdata = 8'h00;
                endcase
            end else if (a == REG_IRQ_STATUS) begin
                s_d.rdata = 8'(s_q.irqStatus);
            end else if (a == REG_IRQ_MASK) begin
                s_d.rdata = 8'(s_q.irqMask);
            end else if (a == REG_OSC_FREQ) begin
                s_d.rdata = {4'h0, oscillatorFreqCode};
            end
        end
    end

    // State register; sync reset loads fuse defaults
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < CHANNELS; i++) begin
                s_q.runV[i] <= fuseCfg[i].voltageDefault;
                s_q.stbyV[i] <= fuseCfg[i].voltageDefault;
                s_q.runMode[i] <=
                    modeDefault(fuseCfg[i].inSequence);
                s_q.stbyMode[i] <=
                    modeDefault(fuseCfg[i].inSequence);
                s_q.appliedMode[i] <= modeDefault(fuseCfg[i].inSequence);
                s_q.ramp[i] <= fuseCfg[i].rampDefault;
                s_q.ilim[i] <= ILIM_RESET;
                s_q.phase[i] <= fuseCfg[i].phaseDefault;
            end
            s_q.irqStatus <= '0;
            s_q.irqMask <= MASK_RESET[CHANNELS-1:0];
            s_q.rdata <= 8'h00;
            s_q.oscAcc <= '0;
            s_q.oscSlot <= '0;
            s_q.oscTick <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Stage controls; phase 7 means no shift, code n shifts by n+1 slots
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            logic [2:0] slot;
            slot = (s_q.phase[i] == PHASE_ZERO) ? 3'h0
                                                : s_q.phase[i] + 3'h1;
            chanOut[i].voltageCode = effCode[i];
            chanOut[i].mode = s_q.appliedMode[i];
            // Off mode or a 1.8 V jump holds the stage off
            chanOut[i].enable = (s_q.appliedMode[i] != MODE_OFF)
                                && !blanked[i];
            chanOut[i].currentLimit = s_q.ilim[i];
            chanOut[i].phase = s_q.phase[i];
            chanOut[i].inductorSelect =
                fuseCfg[i].inductorSelect;
            chanOut[i].switchPulse = s_q.oscTick
                                     && s_q.oscSlot == slot;
            chanOut[i].ramping = ramping[i];
        end
    end

    assign regRdata = s_q.rdata;
    // Active low while any unmasked status bit stands
    assign irqOutN = ~|(s_q.irqStatus & ~s_q.irqMask);

endmodule
`default_nettype wire

// ### verification/buck_setpoint_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module buck_setpoint_ctrl_asserts import buck_ctrl_pkg::*; #(
    parameter int CHANNELS = NUM_CH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Design inputs
    input wire fuse_cfg_t [CHANNELS-1:0] fuseCfg,
    input wire logic [3:0] oscillatorFreqCode,
    input wire logic standbyState,
    input wire reg_req_t regReq,
    // Design outputs
    input wire logic [7:0] regRdata,
    input wire chan_out_t [CHANNELS-1:0] chanOut,
    input wire logic irqOutN
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Channel zero carries the detailed voltage checks
    logic [7:0] code;
    logic [2*CHANNELS-1:0] modes;
    assign code = chanOut[0].voltageCode;
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            modes[2*i +: 2] = chanOut[i].mode;
        end
    end

    chk_step_one: assert property (
        !$past(reset) && $changed(code) && code != VCODE_HIGH
        && $past(code) != VCODE_HIGH |-> $past(chanOut[0].ramping)
        && (code == $past(code) + 8'h01 || code == $past(code) - 8'h01))
        else $error("voltage code moved by more than one step");
    chk_jump_blank: assert property (
        !$past(reset) && $changed(code)
        && (code == VCODE_HIGH || $past(code) == VCODE_HIGH)
        |-> !$past(chanOut[0].enable))
        else $error("jump to or from high code without disable");
    chk_off_disabled: assert property (
        chanOut[0].mode == MODE_OFF |-> !chanOut[0].enable)
        else $error("channel enabled in off mode");
    chk_irq_cause: assert property (
        $fell(irqOutN) |-> modes != $past(modes)
        || ($past(regReq.write) && $past(regReq.addr) == REG_IRQ_MASK))
        else $error("interrupt pin fell without a mode change");
    chk_osc_read: assert property (
        regReq.read && regReq.addr == REG_OSC_FREQ
        |=> regRdata == {4'h0, $past(oscillatorFreqCode)})
        else $error("oscillator code read back wrong");
    chk_reserved_keep: assert property (
        regReq.write && regReq.addr == 8'h00 && regReq.wdata > VCODE_HIGH
        && !$past(regReq.write) && !chanOut[0].ramping && !standbyState
        |=> $stable(code) [*8])
        else $error("reserved voltage code acted on");
    chk_fuse_load: assert property (
        $past(reset) |-> code == fuseCfg[0].voltageDefault
        && chanOut[0].phase == fuseCfg[0].phaseDefault)
        else $error("fuse defaults not loaded");
    chk_mode_load: assert property (
        $past(reset) |-> chanOut[0].mode
        == (fuseCfg[0].inSequence ? MODE_AUTO : MODE_OFF))
        else $error("mode reset value wrong");
    chk_pulse_single: assert property (
        chanOut[0].switchPulse |=> !chanOut[0].switchPulse [*8])
        else $error("switching pulses too close");
endmodule

bind buck_setpoint_ctrl buck_setpoint_ctrl_asserts #(
    .CHANNELS(CHANNELS)
) u_buck_setpoint_ctrl_asserts (
    .clk(clk),
    .reset(reset),
    .fuseCfg(fuseCfg),
    .oscillatorFreqCode(oscillatorFreqCode),
    .standbyState(standbyState),
    .regReq(regReq),
    .regRdata(regRdata),
    .chanOut(chanOut),
    .irqOutN(irqOutN)
);
`default_nettype wire

// ### verification/host_sw_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_sw_model import buck_ctrl_pkg::*; (
    // Clock
    input wire logic clk,
    // Register port
    output var reg_req_t regReq,
    input wire logic [7:0] regRdata
);
    initial regReq = '{write: 1'b0, read: 1'b0, addr: 8'hFF, wdata: 8'hFF};

    // One-cycle strobe; released fields go inverted so stale values never pass
    task automatic access(input logic wr, input logic [7:0] a,
        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        #1;
        regReq = '{write: wr, read: !wr, addr: a, wdata: d};
        @(posedge clk);
        #1;
        regReq = '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
        q = regRdata;
    endtask
endmodule
`default_nettype wire

// ### verification/buck_setpoint_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module buck_setpoint_ctrl_tb_top import buck_ctrl_pkg::*;;
    typedef struct {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic doWr;
        logic [7:0] exp;
    } row_t;
    logic clk, reset, standbyState, irqOutN;
    logic [3:0] oscillatorFreqCode;
    logic [7:0] regRdata, q;
    fuse_cfg_t [NUM_CH-1:0] fuseCfg;
    reg_req_t regReq;
    chan_out_t [NUM_CH-1:0] chanOut;
    int errTotal = 0;
    int testsRun = 0;
    int cycles = 0;
    int n;
    // Plain register accesses: address, data, write or not, read-back
    row_t rows [11] = '{
        '{8'h01, 8'h30, 1'b1, 8'h30},
        '{8'h00, 8'hB2, 1'b1, 8'h10},
        '{8'h08, 8'h00, 1'b0, 8'hB1},
        '{8'h09, 8'h00, 1'b0, 8'hB1},
        '{8'h03, 8'h00, 1'b0, 8'h21},
        '{8'h0B, 8'h5C, 1'b1, 8'h5C},
        '{8'h05, 8'h00, 1'b0, 8'h01},
        '{8'h22, 8'h00, 1'b0, 8'h00},
        '{8'h30, 8'h55, 1'b1, 8'h00},
        '{8'h04, 8'h77, 1'b1, 8'h10},
        '{8'h21, 8'h00, 1'b0, 8'h00}
    };

    buck_setpoint_ctrl u_buck_setpoint_ctrl (
        .clk(clk),
        .reset(reset),
        .fuseCfg(fuseCfg),
        .oscillatorFreqCode(oscillatorFreqCode),
        .standbyState(standbyState),
        .regReq(regReq),
        .regRdata(regRdata),
        .chanOut(chanOut),
        .irqOutN(irqOutN)
    );
    host_sw_model u_host_sw_model (
        .clk(clk),
        .regReq(regReq),
        .regRdata(regRdata)
    );

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Watchdog; the sequence needs roughly 10000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errTotal = errTotal + 1;
            conclude();
        end
    end

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic checkVal(input logic [7:0] got, input logic [7:0] exp,
        input string what);
        testsRun++;
        if (got !== exp) begin
            errTotal++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        u_host_sw_model.access(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        u_host_sw_model.access(1'b0, a, 8'h00, r);
    endtask
    // Bounded wait for a channel's applied code; returns cycles waited
    task automatic waitCode(input int ch, input logic [7:0] c, output int k);
        k = 0;
        while (chanOut[ch].voltageCode !== c && k < 8000) begin
            tick(1);
            k++;
        end
        checkVal(chanOut[ch].voltageCode, c, "applied code");
    endtask
    // Switching pulses of channel two seen over a window of k cycles
    task automatic countPulses(input int k, output int p);
        p = 0;
        repeat (k) begin
            tick(1);
            p += chanOut[2].switchPulse;
        end
    endtask

    initial begin
        reset = 1'b1;
        standbyState = 1'b0;
        oscillatorFreqCode = 4'h0;
        fuseCfg[0] = '{8'h10, 2'h1, 3'h2, 2'h1, 1'b1};
        fuseCfg[1] = '{8'hB1, 2'h0, 3'h7, 2'h0, 1'b0};
        fuseCfg[2] = '{8'h20, 2'h2, 3'h5, 2'h2, 1'b1};
        fuseCfg[3] = '{8'h40, 2'h3, 3'h0, 2'h0, 1'b0};
        tick(3);
        reset = 1'b0;
        // Fuse defaults on every channel
        for (int c = 0; c < NUM_CH; c++) begin
            checkVal(chanOut[c].voltageCode, fuseCfg[c].voltageDefault,
                "fuse code");
            checkVal({6'h0, chanOut[c].mode},
                fuseCfg[c].inSequence ? 8'h03 : 8'h00, "mode");
            checkVal({5'h0, chanOut[c].phase}, {5'h0, fuseCfg[c].phaseDefault},
                "phase");
            checkVal({6'h0, chanOut[c].currentLimit}, 8'h00,
                "ilim");
            checkVal({6'h0, chanOut[c].inductorSelect},
                {6'h0, fuseCfg[c].inductorSelect}, "lsel");
        end
        checkVal({7'h0, irqOutN}, 8'h01, "irq idle");
        foreach (rows[i]) begin
            if (rows[i].doWr)
                wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, q);
            checkVal(q, rows[i].exp, "register");
        end
        checkVal({5'h0, chanOut[1].phase}, 8'h05, "phase out");
        checkVal({6'h0, chanOut[1].currentLimit}, 8'h03, "ilim");
        // Up three steps at code 01: 8 ticks of 6.25 clocks each
        wr(8'h00, 8'h13);
        waitCode(0, 8'h11, n);
        checkVal({7'h0, chanOut[0].ramping}, 8'h01, "ramping");
        waitCode(0, 8'h12, n);
        checkVal(8'(n >= 49 && n <= 51), 8'h01, "up spacing");
        waitCode(0, 8'h13, n);
        // Rewritten rate code 10, downward: 48 ticks per step
        wr(8'h03, 8'h22);
        wr(8'h00, 8'h10);
        waitCode(0, 8'h12, n);
        waitCode(0, 8'h11, n);
        checkVal(8'(n >= 299 && n <= 301), 8'h01, "down spacing");
        waitCode(0, 8'h10, n);
        // Jump to the high code: output off first, then loaded directly
        wr(8'h00, VCODE_HIGH);
        for (n = 0; n < 5 && chanOut[0].enable !== 1'b0; n++)
            tick(1);
        checkVal({7'h0, chanOut[0].enable}, 8'h00, "off first");
        checkVal(chanOut[0].voltageCode, 8'h10, "code off");
        waitCode(0, VCODE_HIGH, n);
        tick(1);
        checkVal({7'h0, chanOut[0].enable}, 8'h01, "re-enable");
        wr(8'h00, 8'h10);
        waitCode(0, 8'h10, n);
        // Every mode code on channel three, each change flagged
        for (int m = 1; m <= 4; m++) begin
            wr(8'h1A, 8'(m % 4));
            tick(1);
            checkVal({6'h0, chanOut[3].mode}, 8'(m % 4), "mode");
            checkVal({7'h0, chanOut[3].enable}, 8'(m < 4), "en");
            checkVal({7'h0, irqOutN}, 8'h00, "irq set");
            wr(8'h20, 8'h08);
            tick(1);
            checkVal({7'h0, irqOutN}, 8'h01, "irq clear");
        end
        // Start channel two in forced pulse-width, then mask and unmask
        wr(8'h12, 8'h0D);
        tick(1);
        wr(8'h21, 8'h04);
        checkVal({7'h0, irqOutN}, 8'h01, "masked");
        rd(8'h20, q);
        checkVal(q, 8'h04, "status");
        wr(8'h21, 8'h00);
        checkVal({7'h0, irqOutN}, 8'h00, "unmasked");
        wr(8'h20, 8'h04);
        // Standby selects the standby mode and voltage
        standbyState = 1'b1;
        tick(3);
        checkVal({6'h0, chanOut[2].mode}, 8'h03, "stby mode");
        checkVal({7'h0, irqOutN}, 8'h00, "stby irq");
        checkVal({7'h0, chanOut[0].ramping}, 8'h01, "stby ramp");
        waitCode(0, 8'h30, n);
        // Eight oscillator ticks per switching period, both code ranges
        countPulses(400, n);
        checkVal(8'(n), 8'h08, "pulses code 0");
        oscillatorFreqCode = 4'h9;
        countPulses(500, n);
        checkVal(8'(n), 8'h08, "pulses code 9");
        // Reset mid-run reloads fuse defaults over written values
        reset = 1'b1;
        tick(2);
        reset = 1'b0;
        checkVal(chanOut[0].voltageCode, 8'h10, "reload code");
        checkVal({5'h0, chanOut[1].phase}, 8'h07, "re-phase");
        checkVal({7'h0, irqOutN}, 8'h01, "reload irq");
        conclude();
    end
endmodule
`default_nettype wire
